// ### lmi_pkg.sv
package lmi_pkg;

  // ==========================================================================
  // Instruction encodings (14-bit words)
  localparam logic [13:0] ENC_IDLE = 14'h0000;
  localparam logic [13:0] ENC_RESET = 14'h0001;
  localparam logic [13:0] ENC_IRQ_RET = 14'h0009;
  localparam logic [13:0] ENC_OPTION = 14'h0062;
  localparam logic [13:0] MSK_BANK = 14'h3fe0;
  localparam logic [13:0] ENC_BANK = 14'h0020;
  localparam logic [13:0] MSK_PCH = 14'h3f80;
  localparam logic [13:0] ENC_PCH = 14'h3180;
  localparam logic [13:0] MSK_ACCLIT = 14'h3f00;
  localparam logic [13:0] ENC_ACCLIT = 14'h3000;
  localparam logic [13:0] MSK_FILE = 14'h3f80;
  localparam logic [13:0] ENC_FILE = 14'h0080;
  localparam logic [13:0] MSK_IND = 14'h3ff8;
  localparam logic [13:0] ENC_IND = 14'h0018;
  localparam logic [13:0] MSK_IND_REL = 14'h3f80;
  localparam logic [13:0] ENC_IND_REL = 14'h3f80;

  // ==========================================================================
  // Indirect update modes
  localparam logic [1:0] MODE_PRE_INC = 2'b00;
  localparam logic [1:0] MODE_PRE_DEC = 2'b01;
  localparam logic [1:0] MODE_POST_INC = 2'b10;
  localparam logic [1:0] MODE_POST_DEC = 2'b11;

  // ==========================================================================
  // Register offsets (byte addresses) and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h04;
  localparam logic [7:0] OFS_PTR0 = 8'h08;
  localparam logic [7:0] OFS_PTR1 = 8'h0c;
  localparam logic [7:0] OFS_OPTION = 8'h10;
  localparam logic [7:0] OFS_PWRCTL = 8'h14;
  localparam logic [7:0] OFS_IRQCTL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int PWRCTL_RSTFLAG_BIT = 0;
  localparam int IRQCTL_IRQEN_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [6:0] PCH_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic RSTFLAG_RST = 1'b1;
  localparam logic RUN_RST = 1'b0;

  // ==========================================================================
  // Types
  typedef enum logic [9:0] {
    OP_IDLE = 10'h001, OP_BANK = 10'h002, OP_PCH = 10'h004, OP_ACCLIT = 10'h008,
    OP_FILE = 10'h010, OP_IND = 10'h020, OP_IND_REL = 10'h040, OP_OPTION = 10'h080,
    OP_RESET = 10'h100, OP_IRQ_RET = 10'h200
  } lmi_op_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001, ST_FLUSH = 3'b010, ST_SWRST = 3'b100
  } lmi_state_t;

endpackage

// ### lmi_decode.sv
`timescale 1ns/1ns
module lmi_decode
  import lmi_pkg::*;
(
  input wire logic [13:0] instr_word,
  output lmi_pkg::lmi_op_t op,
  output logic [7:0] lit,
  output logic [1:0] mode,
  output logic sel,
  output logic [5:0] offset
);

  // ==========================================================================
  // Word classification
  function automatic logic hit(input logic [13:0] w, input logic [13:0] m,
                               input logic [13:0] e);
    hit = ((w & m) == e);
  endfunction

  // Fixed words first; words outside this slice run as idle
  always_comb begin
    if (instr_word == ENC_IDLE) begin
      op = OP_IDLE;
    end else if (instr_word == ENC_RESET) begin
      op = OP_RESET;
    end else if (instr_word == ENC_IRQ_RET) begin
      op = OP_IRQ_RET;
    end else if (instr_word == ENC_OPTION) begin
      op = OP_OPTION;
    end else if (hit(instr_word, MSK_BANK, ENC_BANK)) begin
      op = OP_BANK;
    end else if (hit(instr_word, MSK_FILE, ENC_FILE)) begin
      op = OP_FILE;
    end else if (hit(instr_word, MSK_IND, ENC_IND)) begin
      op = OP_IND;
    end else if (hit(instr_word, MSK_IND_REL, ENC_IND_REL)) begin
      op = OP_IND_REL;
    end else if (hit(instr_word, MSK_PCH, ENC_PCH)) begin
      op = OP_PCH;
    end else if (hit(instr_word, MSK_ACCLIT, ENC_ACCLIT)) begin
      op = OP_ACCLIT;
    end else begin
      op = OP_IDLE;
    end
  end

  // Operand fields
  assign lit = instr_word[7:0];
  assign mode = instr_word[1:0];
  assign sel = (op == OP_IND_REL) ? instr_word[6] : instr_word[2];
  assign offset = instr_word[5:0];

endmodule

// ### lmi_ptr_unit.sv
`timescale 1ns/1ns
module lmi_ptr_unit
  import lmi_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire logic [1:0] mode,
  input wire logic rel,
  input wire logic [5:0] offset,
  output logic [15:0] eff_addr,
  output logic [15:0] next_ptr
);

  // ==========================================================================
  // Address arithmetic; 16-bit sums wrap on their own
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_rel;

  assign ptr_inc = ptr + 16'h0001;
  assign ptr_dec = ptr - 16'h0001;
  assign ptr_rel = ptr + {{10{offset[5]}}, offset};

  // Pre modes address the updated value, post modes the old one
  always_comb begin
    eff_addr = ptr;
    next_ptr = ptr;
    if (rel) begin
      eff_addr = ptr_rel;
    end else begin
      unique case (mode)
        MODE_PRE_INC: begin
          eff_addr = ptr_inc;
          next_ptr = ptr_inc;
        end
        MODE_PRE_DEC: begin
          eff_addr = ptr_dec;
          next_ptr = ptr_dec;
        end
        MODE_POST_INC: begin
          next_ptr = ptr_inc;
        end
        MODE_POST_DEC: begin
          next_ptr = ptr_dec;
        end
      endcase
    end
  end

endmodule

// ### lmi_core.sv
// Summary of operation
// [RQ1] Bank literal loads bank select, flags kept
// [RQ2] Seven-bit literal loads pc high latch
// [RQ3] Accumulator stored to banked file address
// [RQ4] Indirect store writes where pointer points
// [RQ5] Mode field picks pre/post increment/decrement
// [RQ6] Relative form adds signed offset, pointer kept
// [RQ7] Pointers are 16 bits and wrap
// [RQ8] Indirect store never touches status flags
// [RQ9] Option instruction copies accumulator to option
// [RQ10] Software reset resets core, clears flag
// [RQ11] Interrupt return pops, loads pc, sets enable
// [RQ12] Interrupt return takes two cycles, flushes
// [RQ13] Accumulator literal load, one cycle, flags kept
// [RQ14] Idle instruction only advances program counter
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module lmi_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic [14:0] pc,
  input wire logic [14:0] stack_top,
  output logic stack_pop,
  output logic dmem_we,
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  output logic [7:0] timer_option,
  output logic global_irq_enable,
  output logic soft_reset
);
  import lmi_pkg::*;

  // ==========================================================================
  // Core state
  lmi_state_t state;
  lmi_op_t op;
  logic [7:0] acc;
  logic [4:0] bank_select_reg;
  logic [6:0] pc_high_latch;
  logic [15:0] indirect_pointer [2];
  logic [7:0] status_flags;
  logic reset_instr_flag, run_en;
  logic [7:0] lit;
  logic [1:0] mode;
  logic sel;
  logic [5:0] offset;
  logic [15:0] eff_addr, next_ptr;
  logic take, exec, core_clr, bus_wr, bus_setup;

  // Fetch handshake; nothing is taken during the reset cycle
  assign instr_ready = run_en && (state != ST_SWRST);
  assign take = instr_valid && instr_ready;
  assign exec = take && (state == ST_EXEC);
  assign core_clr = (state == ST_SWRST);
  assign bus_wr = psel && penable && pwrite;
  assign bus_setup = psel && !penable;
  assign pready = 1'b1;

  // ==========================================================================
  // Decode and pointer arithmetic
  lmi_decode u_decode (.instr_word(instr_word), .op(op), .lit(lit), .mode(mode), .sel(sel),
    .offset(offset));

  lmi_ptr_unit u_ptr (.ptr(indirect_pointer[sel]), .mode(mode), .rel(op == OP_IND_REL),
    .offset(offset), .eff_addr(eff_addr), .next_ptr(next_ptr));

  // ==========================================================================
  // Sequencer: interrupt return gets a flush cycle, reset a clear cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_EXEC;
    end else begin
      unique case (state)
        ST_EXEC: begin
          // [RQ12] two-cycle return
          if (exec && op == OP_IRQ_RET) begin
            state <= ST_FLUSH;
          end else if (exec && op == OP_RESET) begin
            state <= ST_SWRST;
          end
        end
        ST_FLUSH: begin
          // [RQ12] flush fetched word
          if (take) begin
            state <= ST_EXEC;
          end
        end
        ST_SWRST: state <= ST_EXEC;
        default: state <= ST_EXEC;
      endcase
    end
  end

  // Program counter advances once per word, flushed word included; a return word loads stack_top instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_RST;
    end else if (core_clr) begin
      pc <= PC_RST;
    end else if (exec && op == OP_IRQ_RET) begin
      // [RQ11] return address loaded
      pc <= stack_top;
    end else if (take) begin
      // [RQ14] idle only advances
      pc <= pc + 15'h0001;
    end
  end

  // Stack pop strobe, one cycle after the return is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pop <= 1'b0;
    end else begin
      // [RQ11] pop the stack
      stack_pop <= exec && (op == OP_IRQ_RET);
    end
  end

  // ==========================================================================
  // Literal loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_reg <= BANK_RST;
    end else if (core_clr) begin
      bank_select_reg <= BANK_RST;
    end else if (exec && op == OP_BANK) begin
      // [RQ1] load bank literal
      bank_select_reg <= lit[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_latch <= PCH_RST;
    end else if (core_clr) begin
      pc_high_latch <= PCH_RST;
    end else if (exec && op == OP_PCH) begin
      // [RQ2] load high latch
      pc_high_latch <= lit[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RST;
    end else if (core_clr) begin
      acc <= ACC_RST;
    end else if (exec && op == OP_ACCLIT) begin
      // [RQ13] accumulator literal
      acc <= lit;
    end
  end

  // Option register: the option instruction writes it, the reset instruction restores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_option <= OPTION_RST;
    end else if (core_clr) begin
      timer_option <= OPTION_RST;
    end else if (exec && op == OP_OPTION) begin
      // [RQ9] copy accumulator
      timer_option <= acc;
    end
  end

  // ==========================================================================
  // Data memory write port, registered so it is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmem_we <= 1'b0;
      dmem_addr <= 16'h0000;
      dmem_wdata <= 8'h00;
    end else begin
      dmem_we <= 1'b0;
      if (exec && op == OP_FILE) begin
        // [RQ3] banked file store
        dmem_we <= 1'b1;
        dmem_addr <= {4'h0, bank_select_reg, lit[6:0]};
        dmem_wdata <= acc;
      end else if (exec && (op == OP_IND || op == OP_IND_REL)) begin
        // [RQ4] store through pointer
        dmem_we <= 1'b1;
        dmem_addr <= eff_addr;
        dmem_wdata <= acc;
      end
    end
  end

  // Pointers: an instruction update wins over a bus write that cycle
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        indirect_pointer[i] <= PTR_RST;
      end else if (core_clr) begin
        indirect_pointer[i] <= PTR_RST;
      end else if (exec && op == OP_IND && sel == 1'(i)) begin
        // [RQ5] [RQ7] update with wrap
        indirect_pointer[i] <= next_ptr;
      end else if (exec && op == OP_IND_REL) begin
        // [RQ6] relative form keeps pointer
        indirect_pointer[i] <= indirect_pointer[i];
      end else if (bus_wr && paddr == (OFS_PTR0 + 8'(4 * i))) begin
        indirect_pointer[i] <= pwdata[15:0];
      end
    end
  end

  // Status flags: only the reset instruction of this slice alters them, clearing them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags <= STATUS_RST;
    end else if (core_clr) begin
      status_flags <= STATUS_RST;
    end else if (bus_wr && paddr == OFS_STATUS) begin
      // [RQ8] only software writes flags
      status_flags <= pwdata[7:0];
    end
  end

  // Global interrupt enable: set by return, software may write it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (core_clr) begin
      global_irq_enable <= 1'b0;
    end else if (exec && op == OP_IRQ_RET) begin
      // [RQ11] enable interrupts
      global_irq_enable <= 1'b1;
    end else if (bus_wr && paddr == OFS_IRQCTL) begin
      global_irq_enable <= pwdata[IRQCTL_IRQEN_BIT];
    end
  end

  // ==========================================================================
  // Software reset: survives in the flag so software sees the cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_instr_flag <= RSTFLAG_RST;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= exec && (op == OP_RESET);
      if (exec && op == OP_RESET) begin
        // [RQ10] clear cause flag
        reset_instr_flag <= 1'b0;
      end else if (bus_wr && paddr == OFS_PWRCTL && pwdata[PWRCTL_RSTFLAG_BIT]) begin
        reset_instr_flag <= 1'b1;
      end
    end
  end

  // Run enable gates fetch; kept over a software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en <= RUN_RST;
    end else if (bus_wr && paddr == OFS_CTRL) begin
      run_en <= pwdata[CTRL_RUN_BIT];
    end
  end

  // ==========================================================================
  // Bus read path: sampled in setup so access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: prdata <= {31'h0, run_en};
        OFS_CORE: prdata <= {1'b0, pc_high_latch, 3'h0, bank_select_reg, 8'h00, acc};
        OFS_PTR0: prdata <= {16'h0000, indirect_pointer[0]};
        OFS_PTR1: prdata <= {16'h0000, indirect_pointer[1]};
        OFS_OPTION: prdata <= {24'h0, timer_option};
        OFS_PWRCTL: prdata <= {31'h0, reset_instr_flag};
        OFS_IRQCTL: prdata <= {24'h0, global_irq_enable, 7'h00};
        OFS_STATUS: prdata <= {24'h0, status_flags};
        default: pslverr <= 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // [RQ1] bank literal loaded
  bank_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ1]
    exec && op == OP_BANK |=> bank_select_reg == $past(lit[4:0]) && $stable(status_flags))
    else $error("bank select not loaded");
  // [RQ2] high latch loaded
  pch_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
    exec && op == OP_PCH |=> pc_high_latch == $past(lit[6:0]))
    else $error("pc high latch not loaded");
  // [RQ3] file store address
  file_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
    exec && op == OP_FILE |=> dmem_we && dmem_wdata == $past(acc)
      && dmem_addr == {4'h0, $past(bank_select_reg), $past(lit[6:0])})
    else $error("file store wrong");
  // [RQ4] indirect store target
  ind_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
    exec && op == OP_IND && mode == MODE_POST_INC |=> dmem_we
      && dmem_addr == $past(indirect_pointer[sel]) && dmem_wdata == $past(acc))
    else $error("indirect store address wrong");
  // [RQ5] [RQ7] pre-increment wraps
  pre_inc_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
    exec && op == OP_IND && mode == MODE_PRE_INC && !sel |=>
      indirect_pointer[0] == 16'($past(indirect_pointer[0]) + 16'h0001)
      && dmem_addr == indirect_pointer[0])
    else $error("pre increment wrong");
  // [RQ6] relative keeps pointer
  rel_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
    exec && op == OP_IND_REL |=> $stable(indirect_pointer[0]) && $stable(indirect_pointer[1])
      && dmem_addr == 16'($past(indirect_pointer[sel]) + {{10{$past(offset[5])}}, $past(offset)}))
    else $error("relative store wrong");
  // [RQ8] flags only by software
  flags_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
    !(bus_wr && paddr == OFS_STATUS) && !core_clr |=> $stable(status_flags))
    else $error("status flags changed");
  // [RQ9] option copy
  option_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    exec && op == OP_OPTION |=> timer_option == $past(acc))
    else $error("option not loaded");
  // [RQ10] reset sequence
  soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    exec && op == OP_RESET |=> soft_reset && !reset_instr_flag && core_clr
      ##1 pc == PC_RST && acc == ACC_RST)
    else $error("software reset wrong");
  // [RQ11] [RQ12] return sequence
  irq_return_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
    exec && op == OP_IRQ_RET |=> stack_pop && global_irq_enable
      && pc == $past(stack_top) && state == ST_FLUSH)
    else $error("interrupt return wrong");
  // [RQ12] flushed word has no effect
  flush_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    state == ST_FLUSH && take |=> !dmem_we && $stable(acc) && state == ST_EXEC)
    else $error("flush executed a word");
  // [RQ13] [RQ14] one cycle per word
  acc_lit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    exec && op == OP_ACCLIT |=> acc == $past(lit) && pc == 15'($past(pc) + 15'h0001))
    else $error("accumulator literal wrong");
  // [RQ14] idle keeps state
  idle_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    exec && op == OP_IDLE |=> !dmem_we && $stable(acc) && pc == 15'($past(pc) + 15'h0001))
    else $error("idle changed state");
  return_c: cover property (@(posedge pclk) disable iff (!presetn)
    exec && op == OP_IRQ_RET ##1 take);
  rel_store_c: cover property (@(posedge pclk) disable iff (!presetn)
    exec && op == OP_IND_REL && offset[5]);
  reset_c: cover property (@(posedge pclk) disable iff (!presetn)
    exec && op == OP_RESET);
  wrap_c: cover property (@(posedge pclk) disable iff (!presetn)
    exec && op == OP_IND && mode == MODE_POST_DEC && indirect_pointer[sel] == 16'h0000);

endmodule

// ### lmi_prog_mem.sv
`timescale 1ns/1ns
module lmi_prog_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word
);
  // ==========================================================
  // Word store filled by the bench, read in order
  logic [13:0] mem [64];
  int rd_i = 0;
  int wr_i = 0;
  logic slow = 1'b0;
  logic gap = 1'b0;
  logic [13:0] last_word = 14'h0000;

  // Between words the bus shows the inverse of the last word taken, not a stale word
  assign instr_valid = (rd_i < wr_i) && !gap;
  assign instr_word = instr_valid ? mem[rd_i] : ~last_word;

  // Non-blocking so a word pushed at an edge is not taken at that edge
  task automatic push(input logic [13:0] w);
    mem[wr_i] <= w;
    wr_i <= wr_i + 1;
  endtask

  // Slow mode makes every other cycle an empty cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 1'b0;
    end else begin
      gap <= slow ? ~gap : 1'b0;
      if (instr_valid && instr_ready) begin
        rd_i <= rd_i + 1;
        last_word <= instr_word;
      end
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import lmi_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, instr_valid, instr_ready, stack_pop, dmem_we;
  logic global_irq_enable, soft_reset;
  logic [13:0] instr_word;
  logic [14:0] pc;
  logic [14:0] stack_top = 15'h2abc;
  logic [15:0] dmem_addr;
  logic [7:0] dmem_wdata, timer_option;
  int miscompares = 0;
  int checks = 0;
  int pops = 0;
  int swrsts = 0;
  logic [23:0] wr_log [$];
  logic [23:0] exp_wr [7] = '{24'h07c55a, 24'h00005a, 24'hffff5a, 24'h12345a,
                             24'h12355a, 24'hffdf5a, 24'h12535a};
  logic [13:0] prog1 [$] = '{14'h305a, 14'h002f, 14'h31ff, 14'h00c5, 14'h0018,
                            14'h0019, 14'h001e, 14'h001f, 14'h3fa0, 14'h3fdf,
                            14'h0062, 14'h0009, 14'h0000};
  logic [13:0] prog2 [$] = '{14'h0000, 14'h0001};
  logic [31:0] rd;
  logic err;

  always #5 pclk = ~pclk;

  lmi_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .pc(pc), .stack_top(stack_top), .stack_pop(stack_pop),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .timer_option(timer_option), .global_irq_enable(global_irq_enable),
    .soft_reset(soft_reset));

  lmi_prog_mem i_pm (.pclk(pclk), .presetn(presetn), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word));

  // ==========================================================
  // Monitor of data writes and pulses
  always @(posedge pclk) begin
    if (dmem_we === 1'b1) wr_log.push_back({dmem_addr, dmem_wdata});
    if (stack_pop === 1'b1) pops++;
    if (soft_reset === 1'b1) swrsts++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; only the watchdog bounds the wait for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Feed a program one word per cycle, then wait until it is consumed
  task automatic run(input logic [13:0] p [$]);
    foreach (p[i]) begin
      @(posedge pclk);
      i_pm.push(p[i]);
    end
    do begin
      @(posedge pclk);
    end while (i_pm.rd_i != i_pm.wr_i);
    repeat (4) @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_OPTION, 32'hff);
    rdchk(OFS_PWRCTL, 32'h1);
    rdchk(OFS_CTRL, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, 8'h20, 32'h5);
    chk({31'h0, err}, 32'h1);
    rdchk(8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_PTR0, 32'hffff);
    apb(1'b1, OFS_PTR1, 32'h1234);
    apb(1'b1, OFS_STATUS, 32'ha5);
    apb(1'b1, OFS_CTRL, 32'h1);
    run(prog1);
    foreach (exp_wr[i]) begin
      chk({8'h0, wr_log[i]}, {8'h0, exp_wr[i]});
    end
    chk(wr_log.size(), 32'd7);
    rdchk(OFS_CORE, 32'h7f0f005a);
    rdchk(OFS_PTR0, 32'hffff);
    rdchk(OFS_PTR1, 32'h1234);
    rdchk(OFS_STATUS, 32'ha5);
    chk({24'h0, timer_option}, 32'h5a);
    chk({31'h0, global_irq_enable}, 32'h1);
    rdchk(OFS_IRQCTL, 32'h80);
    chk({17'h0, pc}, 32'h2abd);
    chk(pops, 32'd1);
    i_pm.slow = 1'b1;
    run(prog2);
    chk(swrsts, 32'd1);
    chk(wr_log.size(), 32'd7);
    rdchk(OFS_PWRCTL, 32'h0);
    rdchk(OFS_CORE, 32'h0);
    rdchk(OFS_OPTION, 32'hff);
    rdchk(OFS_CTRL, 32'h1);
    chk({17'h0, pc}, 32'h0);
    apb(1'b1, OFS_PWRCTL, 32'h1);
    rdchk(OFS_PWRCTL, 32'h1);
    end_of_test();
  end

  // Watchdog: the whole run needs under a hundred cycles
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule
